// file: common/fsa_defines.svh
`ifndef FSA_DEFINES_SVH
`define FSA_DEFINES_SVH
// Core clock rate
`define FSA_CLK_HZ 250000000
// Register byte offsets
`define FSA_OFF_CTRL 5'h00
`define FSA_OFF_CLR 5'h04
`define FSA_OFF_MASK 5'h08
`define FSA_OFF_STAT 5'h0c
// Control register field positions
`define FSA_B_SBY 0
`define FSA_B_KICK 1
`define FSA_B_ENOVR 2
`define FSA_B_EN 3
`define FSA_B_OCPDIS 4
`define FSA_B_TREG 5
`define FSA_B_ILIM 7
`define FSA_B_WDT 9
`define FSA_B_ADCEN 11
`define FSA_CTRL_W 12
// Clear register strobe position
`define FSA_B_ACLR 0
// Status register field positions
`define FSA_B_OTFLAG 16
`define FSA_B_ACTIVE 17
`define FSA_B_OCPLAT 18
`define FSA_B_WDTEXP 19
// Reset values
`define FSA_CTRL_RST 12'h000
`define FSA_MASK_RST 10'h000
// Alert sources, one pending bit each
`define FSA_NSRC 10
`define FSA_S_WDT 0
`define FSA_S_OT 1
`define FSA_S_OCP 2
`define FSA_S_ADC 3
`define FSA_S_SBY 4
`define FSA_S_BUS 5
`define FSA_S_OV 6
`define FSA_S_UV 7
`define FSA_S_LL 8
`define FSA_S_RTY 9
// Temperatures in degrees C
`define FSA_TSHUT_C 8'd160
`define FSA_THYST_C 8'd30
`define FSA_TREG1_C 8'd80
`define FSA_TREG2_C 8'd100
`define FSA_TREG3_C 8'd120
// Switch current limits in 0.1 A units
`define FSA_ILIM1 7'd57
`define FSA_ILIM2 7'd85
`define FSA_ILIM3 7'd100
// Consecutive limited cycles before latch-off
`define FSA_OCP_CYC 4'd8
// Times in their own units
`define FSA_BUS_TO_MS 100
`define FSA_OV_MS 100
`define FSA_WDT_BASE_S 80
`endif

// file: common/fsa_pkg.sv
package fsa_pkg;
  typedef enum logic {st_standby, st_active} fsa_state_t;
  typedef logic [39:0] fsa_count_t;
endpackage

// file: src/fsa_sticky.sv
`timescale 1ns/1ps
// Sticky pending bits: set wins over clear, hold blocks the clear
module fsa_sticky #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Events and clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] hold,
  input wire logic clr,
  // Pending state
  output logic [W-1:0] pend
);
  // Clear only drops bits whose cause is gone
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= '0;
    end else begin
      pend <= set | (pend & ~({W{clr}} & ~hold)); // [RULE_25]
    end
  end

  a_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
    set[0] |=> pend[0]) else $error("set lost on clear"); // [RULE_25]
endmodule

// file: src/fsa_timer.sv
`timescale 1ns/1ps
// Up counter that flags expiry and holds it until stopped or restarted
module fsa_timer #(
  parameter int W = 40
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [W-1:0] limit,
  // Status
  output logic expired
);
  logic [W-1:0] cnt_reg;

  // Stopping or restarting zeroes the count and the flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else if (restart || !run) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else if (!expired) begin
      if (cnt_reg >= limit - 1'b1) begin
        expired <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  a_tmr_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    restart |=> !expired && cnt_reg == '0)
    else $error("restart did not zero timer"); // [RULE_18]
endmodule

// file: src/fsa_top.sv
// Functional notes
// (RULE_01) Overtemp alert holds until cooled and cleared
// (RULE_02) Overcurrent alert needs standby pass plus clear; here the disable bit plus clear also releases it
// (RULE_03) Finished conversion raises alert when enabled
// (RULE_04) Each standby entry raises a held alert
// (RULE_05) Bus transaction timeout: alert, reset, await start
// (RULE_06) Overvoltage alert in both states, clear releases
// (RULE_07) Undervoltage alert needs range and clear
// (RULE_08) Light-load-off entry alert clears while staying
// (RULE_09) Retry state entry raises held alert
// (RULE_10) Thermal limit field selects 80/100/120, 00 off
// (RULE_11) Start in standby, stay unless enabled
// (RULE_12) Active goes standby on disable or force
// (RULE_13) Overtemp stops converter, auto restart below hysteresis
// (RULE_14) Overtemp flag held until software reads it
// (RULE_15) Switch over limit turns off for cycle
// (RULE_16) Eight consecutive limited cycles latch converter off
// (RULE_17) Latch clears by disable bit or standby
// (RULE_18) Kick restarts watchdog; timeout stops converter
// (RULE_19) Watchdog field selects 80-320 s, 00 off
// (RULE_20) Watchdog stopped and zeroed in standby
// (RULE_21) Override swaps pin for bit; force blocks enable
// (RULE_22) Leave active on force, disable or long overvoltage
// (RULE_23) Alert clear is a strobe reading zero
// (RULE_24) Every source has its own mask bit
// (RULE_25) Alert low while any unmasked source pending
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "fsa_defines.svh"
module fsa_top #(
  parameter fsa_pkg::fsa_count_t BUS_TO_CYC =
    40'(`FSA_BUS_TO_MS * (`FSA_CLK_HZ / 1000)),
  parameter fsa_pkg::fsa_count_t OV_CYC =
    40'(`FSA_OV_MS * (`FSA_CLK_HZ / 1000)),
  parameter fsa_pkg::fsa_count_t WDT_BASE_CYC =
    40'(64'(`FSA_WDT_BASE_S) * 64'(`FSA_CLK_HZ))
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Supervision inputs
  input wire logic en_pin,
  input wire logic [7:0] die_temp,
  input wire logic input_overvolt_hit,
  input wire logic input_undervolt_hit,
  input wire logic adc_done,
  input wire logic light_load_off_state,
  input wire logic retry_state,
  input wire logic bus_start,
  input wire logic bus_stop,
  input wire logic sw_cycle_start,
  input wire logic [3:0][6:0] sw_current,
  // Outputs
  output logic fault_alert_n,
  output logic converter_on,
  output logic active_state,
  output logic [3:0] sw_off,
  output logic current_reduce,
  output logic bus_reset
);
  localparam int NS = `FSA_NSRC;

  // Counts must be nonzero and the longest watchdog must fit
  if (BUS_TO_CYC == 0 || OV_CYC == 0 || WDT_BASE_CYC == 0 ||
      WDT_BASE_CYC > 40'h3f_ffff_ffff) begin : g_chk
    $error("fsa_top: unusable timing parameter");
  end

  logic rst_meta_reg, rst_sync_n;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [`FSA_CTRL_W-1:0] ctrl_reg;
  logic [NS-1:0] mask_reg;
  logic [NS-1:0] pend, set_v, hold_v;
  logic wr_take, rd_look, kick, aclr;
  logic [31:0] bemask, rd_val;
  fsa_pkg::fsa_state_t state_reg, state_next;
  logic enable_ok, sby_evt;
  logic ot_shut_reg, ot_flag_reg, ot_hold;
  logic [6:0] ilim;
  logic [3:0] over;
  logic hit_reg, ocp_latch_reg;
  logic [3:0] ocp_cnt_reg;
  logic in_trans_reg, bus_exp, bus_evt;
  logic ov_exp, wdt_exp, wdt_run;
  fsa_pkg::fsa_count_t wdt_lim;
  logic ll_prev_reg, rty_prev_reg;
  logic [7:0] treg_lim;

  // Reset released through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // Bus strobes: each request answers one cycle after it is seen
  assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_take = avs_write && !wait_reg;
  assign rd_look = avs_read && wait_reg;
  assign kick = wr_take && avs_address == `FSA_OFF_CTRL &&
                avs_byteenable[0] && avs_writedata[`FSA_B_KICK];
  assign aclr = wr_take && avs_address == `FSA_OFF_CLR &&
                avs_byteenable[0] && avs_writedata[`FSA_B_ACLR];

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wait_reg <= 1'b1;
    end else if ((avs_read || avs_write) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end
  assign avs_waitrequest = wait_reg;

  // Read mux; unmapped offsets read zero, strobes read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (avs_address == `FSA_OFF_CTRL) begin
      rd_val[`FSA_CTRL_W-1:0] = ctrl_reg; // Kick is never stored [RULE_18]
    end else if (avs_address == `FSA_OFF_CLR) begin
      rd_val = 32'h0000_0000; // [RULE_23]
    end else if (avs_address == `FSA_OFF_MASK) begin
      rd_val[NS-1:0] = mask_reg;
    end else if (avs_address == `FSA_OFF_STAT) begin
      rd_val[NS-1:0] = pend;
      rd_val[`FSA_B_OTFLAG] = ot_flag_reg;
      rd_val[`FSA_B_ACTIVE] = state_reg == fsa_pkg::st_active;
      rd_val[`FSA_B_OCPLAT] = ocp_latch_reg;
      rd_val[`FSA_B_WDTEXP] = wdt_exp;
    end
  end

  // Read data captured as waitrequest falls, stands through the take
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_look) begin
      rdata_reg <= rd_val;
    end
  end
  assign avs_readdata = rdata_reg;

  // Control register, byte lanes honoured; kick bit stays zero
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_reg <= `FSA_CTRL_RST;
    end else if (wr_take && avs_address == `FSA_OFF_CTRL) begin
      ctrl_reg <= (ctrl_reg & ~bemask[`FSA_CTRL_W-1:0]) |
                  (avs_writedata[`FSA_CTRL_W-1:0] &
                   bemask[`FSA_CTRL_W-1:0] &
                   ~(`FSA_CTRL_W'(1) << `FSA_B_KICK)); // [RULE_18]
    end
  end

  // Mask register, one bit per source
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_reg <= `FSA_MASK_RST;
    end else if (wr_take && avs_address == `FSA_OFF_MASK) begin
      mask_reg <= (mask_reg & ~bemask[NS-1:0]) |
                  (avs_writedata[NS-1:0] & bemask[NS-1:0]); // [RULE_24]
    end
  end

  // Enable: override bit swaps pin for register bit
  assign enable_ok = !ctrl_reg[`FSA_B_SBY] &&
                     (ctrl_reg[`FSA_B_ENOVR] ? ctrl_reg[`FSA_B_EN]
                                             : en_pin); // [RULE_21]

  // Standby / active sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fsa_pkg::st_standby: begin
        if (enable_ok) begin
          state_next = fsa_pkg::st_active; // [RULE_11]
        end
      end
      fsa_pkg::st_active: begin
        if (!enable_ok || ov_exp) begin
          state_next = fsa_pkg::st_standby; // [RULE_12] [RULE_22]
        end
      end
      default: state_next = fsa_pkg::st_standby;
    endcase
  end
  assign sby_evt = state_reg == fsa_pkg::st_active &&
                   state_next == fsa_pkg::st_standby;

  // Power-up always lands in standby
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= fsa_pkg::st_standby; // [RULE_11]
    end else begin
      state_reg <= state_next;
    end
  end

  // Overvoltage must persist while active before forcing standby
  fsa_timer #(.W(40)) u_ov_tmr (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .run(state_reg == fsa_pkg::st_active && input_overvolt_hit),
    .restart(1'b0),
    .limit(OV_CYC),
    .expired(ov_exp)
  ); // [RULE_22]

  // Thermal shutdown with hysteresis, flag held until read
  assign ot_hold = die_temp >= 8'(`FSA_TSHUT_C - `FSA_THYST_C);
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ot_shut_reg <= 1'b0;
    end else if (die_temp > `FSA_TSHUT_C) begin
      ot_shut_reg <= 1'b1; // [RULE_13]
    end else if (!ot_hold) begin
      ot_shut_reg <= 1'b0; // [RULE_13]
    end
  end

  // Status read clears the flag, but a live shutdown keeps it set
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ot_flag_reg <= 1'b0;
    end else if (ot_shut_reg) begin
      ot_flag_reg <= 1'b1; // [RULE_13]
    end else if (rd_look && avs_address == `FSA_OFF_STAT) begin
      ot_flag_reg <= 1'b0; // [RULE_14]
    end
  end

  // Thermal regulation threshold select
  always_comb begin
    case (ctrl_reg[`FSA_B_TREG +: 2])
      2'h1: treg_lim = `FSA_TREG1_C;
      2'h2: treg_lim = `FSA_TREG2_C;
      default: treg_lim = `FSA_TREG3_C;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      current_reduce <= 1'b0;
    end else begin
      current_reduce <= ctrl_reg[`FSA_B_TREG +: 2] != 2'h0 &&
                        die_temp > treg_lim; // [RULE_10]
    end
  end

  // Switch current limit select; code 3 reuses the top limit
  always_comb begin
    case (ctrl_reg[`FSA_B_ILIM +: 2])
      2'h0: ilim = `FSA_ILIM1;
      2'h1: ilim = `FSA_ILIM2;
      default: ilim = `FSA_ILIM3;
    endcase
  end
  for (genvar i = 0; i < 4; i++) begin : g_sw
    assign over[i] = sw_current[i] > ilim;
    // A new cycle releases the switch unless it is still over
    always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        sw_off[i] <= 1'b0;
      end else if (over[i]) begin
        sw_off[i] <= 1'b1; // [RULE_15]
      end else if (sw_cycle_start) begin
        sw_off[i] <= 1'b0;
      end
    end
  end

  // Track whether the running cycle hit the limit
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hit_reg <= 1'b0;
    end else if (sw_cycle_start) begin
      hit_reg <= |over;
    end else begin
      hit_reg <= hit_reg | (|over);
    end
  end

  // Consecutive limited cycles, saturating at the latch count
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ocp_cnt_reg <= 4'h0;
    end else if (ctrl_reg[`FSA_B_OCPDIS] ||
                 state_reg == fsa_pkg::st_standby) begin
      ocp_cnt_reg <= 4'h0;
    end else if (sw_cycle_start) begin
      if (!hit_reg) begin
        ocp_cnt_reg <= 4'h0;
      end else if (ocp_cnt_reg != `FSA_OCP_CYC) begin
        ocp_cnt_reg <= ocp_cnt_reg + 4'h1; // [RULE_16]
      end
    end
  end

  // Latch-off; disable bit or standby clears it
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ocp_latch_reg <= 1'b0;
    end else if (ctrl_reg[`FSA_B_OCPDIS] ||
                 state_reg == fsa_pkg::st_standby) begin
      ocp_latch_reg <= 1'b0; // [RULE_17]
    end else if (ocp_cnt_reg == `FSA_OCP_CYC) begin
      ocp_latch_reg <= 1'b1; // [RULE_16]
    end
  end

  // Watchdog runs only while active and enabled
  always_comb begin
    case (ctrl_reg[`FSA_B_WDT +: 2])
      2'h1: wdt_lim = WDT_BASE_CYC;
      2'h2: wdt_lim = WDT_BASE_CYC << 1;
      default: wdt_lim = WDT_BASE_CYC << 2;
    endcase
  end
  assign wdt_run = state_reg == fsa_pkg::st_active &&
                   ctrl_reg[`FSA_B_WDT +: 2] != 2'h0; // [RULE_19] [RULE_20]
  fsa_timer #(.W(40)) u_wdt (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .run(wdt_run),
    .restart(kick),
    .limit(wdt_lim),
    .expired(wdt_exp)
  ); // [RULE_18]

  // Bus transaction window; a start always restarts it
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      in_trans_reg <= 1'b0;
    end else if (bus_start) begin
      in_trans_reg <= 1'b1; // [RULE_05]
    end else if (bus_stop || bus_exp) begin
      in_trans_reg <= 1'b0; // [RULE_05]
    end
  end
  fsa_timer #(.W(40)) u_bus_tmr (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .run(in_trans_reg),
    .restart(bus_start),
    .limit(BUS_TO_CYC),
    .expired(bus_exp)
  );
  assign bus_evt = bus_exp && in_trans_reg && !bus_start;
  // One-cycle pulse tells the bus engine to drop partial data
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_reset <= 1'b0;
    end else begin
      bus_reset <= bus_evt; // [RULE_05]
    end
  end

  // Edge detectors for the state inputs
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ll_prev_reg <= 1'b0;
      rty_prev_reg <= 1'b0;
    end else begin
      ll_prev_reg <= light_load_off_state;
      rty_prev_reg <= retry_state;
    end
  end

  // Source causes; hold keeps a level source from clearing
  always_comb begin
    set_v = '0;
    hold_v = '0;
    set_v[`FSA_S_WDT] = wdt_exp;
    hold_v[`FSA_S_WDT] = wdt_exp;
    set_v[`FSA_S_OT] = ot_shut_reg; // [RULE_01]
    hold_v[`FSA_S_OT] = ot_hold; // [RULE_01]
    set_v[`FSA_S_OCP] = ocp_latch_reg; // [RULE_02]
    hold_v[`FSA_S_OCP] = ocp_latch_reg; // [RULE_02]
    set_v[`FSA_S_ADC] = adc_done && ctrl_reg[`FSA_B_ADCEN]; // [RULE_03]
    set_v[`FSA_S_SBY] = sby_evt; // [RULE_04]
    set_v[`FSA_S_BUS] = bus_evt; // [RULE_05]
    set_v[`FSA_S_OV] = input_overvolt_hit; // [RULE_06]
    set_v[`FSA_S_UV] = input_undervolt_hit; // [RULE_07]
    hold_v[`FSA_S_UV] = input_undervolt_hit; // [RULE_07]
    set_v[`FSA_S_LL] = light_load_off_state && !ll_prev_reg; // [RULE_08]
    set_v[`FSA_S_RTY] = retry_state && !rty_prev_reg; // [RULE_09]
  end

  fsa_sticky #(.W(NS)) u_pend (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .set(set_v),
    .hold(hold_v),
    .clr(aclr),
    .pend(pend)
  ); // [RULE_23] [RULE_25]

  // Alert and converter outputs straight from flops
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fault_alert_n <= 1'b1;
      converter_on <= 1'b0;
      active_state <= 1'b0;
    end else begin
      fault_alert_n <= ~|(pend & ~mask_reg); // [RULE_24] [RULE_25]
      converter_on <= state_reg == fsa_pkg::st_active && !ot_shut_reg &&
                      !ocp_latch_reg && !wdt_exp; // [RULE_13] [RULE_18]
      active_state <= state_reg == fsa_pkg::st_active;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  a_alert_out: assert property (|(pend & ~mask_reg) |=> !fault_alert_n)
    else $error("unmasked pending without alert"); // [RULE_25]
  a_mask_gate: assert property ((pend & ~mask_reg) == '0 |=> fault_alert_n)
    else $error("masked source drove alert"); // [RULE_24]
  a_ot_stop: assert property (die_temp > `FSA_TSHUT_C |-> ##2 !converter_on)
    else $error("converter on above shutdown"); // [RULE_13]
  a_ot_hold: assert property (pend[`FSA_S_OT] && ot_hold |=> pend[`FSA_S_OT])
    else $error("overtemp alert dropped while hot"); // [RULE_01]
  a_sby_entry: assert property (sby_evt |=> pend[`FSA_S_SBY] &&
    state_reg == fsa_pkg::st_standby)
    else $error("standby entry not flagged"); // [RULE_04]
  a_force_sby: assert property (state_reg == fsa_pkg::st_active &&
    ctrl_reg[`FSA_B_SBY] |=> state_reg == fsa_pkg::st_standby ##1
    !active_state) else $error("force did not reach standby"); // [RULE_12]
  a_ocp_latch: assert property (ocp_cnt_reg == `FSA_OCP_CYC &&
    !ctrl_reg[`FSA_B_OCPDIS] && state_reg == fsa_pkg::st_active
    |=> ocp_latch_reg ##1 !converter_on)
    else $error("latch-off missed"); // [RULE_16]
  a_sw_off: assert property (|over |=> |sw_off)
    else $error("switch not turned off"); // [RULE_15]
  a_wdt_sby: assert property (state_reg == fsa_pkg::st_standby &&
    $past(state_reg) == fsa_pkg::st_standby |-> !wdt_exp)
    else $error("watchdog alive in standby"); // [RULE_20]
  a_bus_to: assert property (bus_evt |=> bus_reset && !in_trans_reg)
    else $error("bus timeout not handled"); // [RULE_05]
  a_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice"); // [RULE_23]

  c_power_on: cover property (state_reg == fsa_pkg::st_standby ##1
    state_reg == fsa_pkg::st_active);
  c_ocp_off: cover property (ocp_latch_reg);
  c_bus_to: cover property (bus_evt);
  c_alert_clr: cover property (!fault_alert_n ##1 aclr ##2 fault_alert_n);
endmodule

// file: dv/fsa_host.sv
`timescale 1ns/1ps
// Controller model: Avalon-MM master with one access task
module fsa_host (
  // Clock
  input wire logic mclk,
  // Avalon-MM master side
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Idle bus at time zero
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  // Request held until waitrequest is sampled low; no fixed wait assumed
  task automatic acc(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
`include "fsa_defines.svh"
module tb;
  // Bus and outputs
  logic mclk, rst_n, rd, wr, wq, al_n, on, act, cr, br;
  logic [4:0] ad;
  logic [31:0] wd, rdat, q;
  logic [3:0] be, so;
  // Supervision stimulus
  logic en_pin, ov, uv, adc, ll, rty, bst, bsp, scs;
  logic [7:0] temp;
  logic [3:0][6:0] cur;
  int bad_count, compares, cyc, n;
  typedef struct {logic [3:0] cv; int b; logic hold;} fsa_row_t;
  // Cause vector {ov, rty, ll, adc}, pending bit, level held during clear
  fsa_row_t rows[4] = '{'{4'h1, `FSA_S_ADC, 1'b0},
    '{4'h2, `FSA_S_LL, 1'b1},
    '{4'h4, `FSA_S_RTY, 1'b1},
    '{4'h8, `FSA_S_OV, 1'b0}};
  fsa_top #(.BUS_TO_CYC(40'd50), .OV_CYC(40'd50), .WDT_BASE_CYC(40'd100))
  fsa_top_i (.mclk(mclk), .rst_n(rst_n), .avs_address(ad), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wq), .en_pin(en_pin),
    .die_temp(temp), .input_overvolt_hit(ov), .input_undervolt_hit(uv),
    .adc_done(adc), .light_load_off_state(ll), .retry_state(rty),
    .bus_start(bst), .bus_stop(bsp), .sw_cycle_start(scs),
    .sw_current(cur), .fault_alert_n(al_n), .converter_on(on),
    .active_state(act), .sw_off(so), .current_reduce(cr), .bus_reset(br));
  fsa_host fsa_host_i (.mclk(mclk), .avs_address(ad), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wq));
  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic cy(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w(input logic [4:0] a, input logic [31:0] d);
    fsa_host_i.acc(1'b1, a, d, q);
  endtask
  task automatic r(input logic [4:0] a);
    fsa_host_i.acc(1'b0, a, 32'h0, q);
  endtask
  // Clear strobe, then let the alert settle
  task automatic clr();
    w(`FSA_OFF_CLR, 32'h1);
    cy(3);
  endtask
  // Opens a transaction, counts bus_reset pulses for gap cycles, stops it only if gap is under 40
  task automatic pulse_bus(input int gap);
    bst <= 1'b1;
    cy(1);
    bst <= 1'b0;
    repeat (gap) begin
      cy(1);
      n += (br === 1'b1);
    end
    bsp <= gap < 40;
    cy(1);
    bsp <= 1'b0;
  endtask
  initial begin
    {rst_n, en_pin, ov, uv, adc, ll, rty, bst, bsp, scs} = 10'h0;
    temp = 8'd25;
    cur = '0;
    cy(3);
    rst_n <= 1'b1;
    cy(4);
    chk("alert", 1, al_n);
    chk("active", 0, act);
    w(`FSA_OFF_CTRL, 32'h800);
    // Table rows: raise cause, see alert and pending, clear
    foreach (rows[i]) begin
      {ov, rty, ll, adc} <= rows[i].cv;
      cy(1);
      {ov, rty, ll, adc} <= rows[i].hold ? rows[i].cv : 4'h0;
      cy(4);
      chk("alert low", 0, al_n);
      r(`FSA_OFF_STAT);
      chk("pending", 1, q[rows[i].b]);
      clr();
      chk("alert high", 1, al_n);
      {ov, rty, ll, adc} <= 4'h0;
      cy(1);
    end
    // Enable by pin, then by override bit, then forced standby
    en_pin <= 1'b1;
    cy(3);
    chk("pin on", 1, act);
    en_pin <= 1'b0;
    cy(3);
    chk("pin off", 0, act);
    r(`FSA_OFF_STAT);
    chk("sby pend", 1, q[`FSA_S_SBY]);
    clr();
    w(`FSA_OFF_CTRL, 32'h80c);
    cy(3);
    chk("ovr on", 1, act);
    w(`FSA_OFF_CTRL, 32'h80d);
    cy(3);
    chk("force", 0, act);
    clr();
    // Watchdog: a kick inside the limit keeps it quiet, then expiry
    w(`FSA_OFF_CTRL, 32'ha0c);
    cy(70);
    w(`FSA_OFF_CTRL, 32'ha0e);
    cy(70);
    chk("wdt kept", 1, on);
    cy(50);
    chk("wdt stop", 0, on);
    r(`FSA_OFF_STAT);
    chk("wdt exp", 1, q[`FSA_B_WDTEXP]);
    w(`FSA_OFF_CTRL, 32'ha0d);
    cy(3);
    r(`FSA_OFF_STAT);
    chk("wdt sby", 0, q[`FSA_B_WDTEXP]);
    clr();
    // Overtemp: clear refused above hysteresis point
    w(`FSA_OFF_CTRL, 32'h80c);
    cy(3);
    temp <= 8'd161;
    cy(4);
    chk("ot stop", 0, on);
    chk("ot alert", 0, al_n);
    temp <= 8'd140;
    clr();
    chk("ot hold", 0, al_n);
    temp <= 8'd100;
    cy(3);
    chk("ot restart", 1, on);
    clr();
    chk("ot release", 1, al_n);
    r(`FSA_OFF_STAT);
    chk("ot flag", 1, q[`FSA_B_OTFLAG]);
    r(`FSA_OFF_STAT);
    chk("ot read clr", 0, q[`FSA_B_OTFLAG]);
    // Thermal regulation at 80 C, then 100 C, then off
    w(`FSA_OFF_CTRL, 32'h82c);
    temp <= 8'd90;
    cy(3);
    chk("treg", 1, cr);
    w(`FSA_OFF_CTRL, 32'h84c);
    cy(3);
    chk("treg 100", 0, cr);
    w(`FSA_OFF_CTRL, 32'h80c);
    cy(3);
    chk("treg off", 0, cr);
    temp <= 8'd25;
    // Switch over 5.7 A for many cycles
    cur[0] <= 7'd60;
    repeat (12) begin
      scs <= 1'b1;
      cy(1);
      scs <= 1'b0;
      cy(3);
    end
    chk("sw off", 1, so[0]);
    chk("ocp stop", 0, on);
    r(`FSA_OFF_STAT);
    chk("ocp latch", 1, q[`FSA_B_OCPLAT]);
    clr();
    chk("ocp hold", 0, al_n);
    cur <= '0;
    w(`FSA_OFF_CTRL, 32'h81c);
    cy(3);
    r(`FSA_OFF_STAT);
    chk("ocp cleared", 0, q[`FSA_B_OCPLAT]);
    chk("ocp resume", 1, on);
    clr();
    // Bus timeout, then a transaction that ends in time
    for (int g = 70; g > 0; g -= 40) begin
      n = 0;
      pulse_bus(g);
      repeat (60) begin
        cy(1);
        n += (br === 1'b1);
      end
      chk("bus reset", g > 40, n);
    end
    r(`FSA_OFF_STAT);
    chk("bus pend", 1, q[`FSA_S_BUS]);
    clr();
    // Masked source stays silent; strobe and unmapped read zero
    w(`FSA_OFF_MASK, 32'h100);
    ll <= 1'b1;
    cy(4);
    chk("masked", 1, al_n);
    ll <= 1'b0;
    r(`FSA_OFF_CLR);
    chk("clr reads", 0, q);
    r(5'h10);
    chk("unmapped", 0, q);
    // Undervoltage clear refused while input still low
    uv <= 1'b1;
    cy(4);
    chk("uv alert", 0, al_n);
    clr();
    chk("uv hold", 0, al_n);
    uv <= 1'b0;
    clr();
    chk("uv release", 1, al_n);
    close_out();
  end
endmodule
